// ### design/fel_top.sv
`timescale 1ns/10ps
`include "fel_defines.svh"
module fel_top #(
  parameter int DEPTH     = 16,
  parameter int LIMIT_W   = 16,
  parameter int REINIT_CY = (`FEL_CLK_HZ / 1000000) * `FEL_REINIT_US,
  parameter int PULSE_CY  = (`FEL_CLK_HZ / 1000000) * `FEL_PULSE_US
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_reset_closed,
  input  wire logic               i_supply_ok,
  input  wire logic               i_lock_closed,
  input  wire logic               i_ack_closed,
  input  wire logic               i_line_tick,
  input  wire logic [31:0]        i_events,
  input  wire logic [31:0]        i_date,
  input  wire logic [23:0]        i_time,
  input  wire logic [LIMIT_W-1:0] i_limit,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    o_fire_enable,
  output logic                    o_setpoint_enable,
  output logic                    o_min_limit_enable,
  output logic                    o_led_red,
  output logic                    o_comm_enable,
  output logic                    o_bus_reset,
  output logic [2:0]              o_relay,
  output logic                    o_status_pending,
  output logic                    o_bus_msg,
  output logic [4:0]              o_bus_msg_event
);
  localparam int PW = $clog2(DEPTH);

  // pin synchronisers
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  always_ff @(posedge i_clk) begin
    pin_meta <= {i_ack_closed, i_lock_closed, i_supply_ok, i_reset_closed};
    pin_sync <= pin_meta;
  end
  wire contact_ok = pin_sync[0];
  wire supply_ok  = pin_sync[1];
  wire lock_open  = ~pin_sync[2];
  wire ack_closed = pin_sync[3];

  fel_pkg::fel_state_e state;
  logic [31:0] reinit_cnt;
  logic        soft_req;
  logic        supply_prev;
  wire hw_reset = ~contact_ok | ~supply_ok;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state      <= fel_pkg::FEL_HOLD;
      reinit_cnt <= '0;
    end else begin
      unique case (state)
        fel_pkg::FEL_RUN: begin
          if (hw_reset || soft_req) begin
            state <= fel_pkg::FEL_HOLD;
          end
        end
        fel_pkg::FEL_HOLD: begin
          reinit_cnt <= '0;
          if (!hw_reset) begin
            state <= fel_pkg::FEL_REINIT;
          end
        end
        fel_pkg::FEL_REINIT: begin
          reinit_cnt <= reinit_cnt + 32'h1;
          if (hw_reset) begin
            state <= fel_pkg::FEL_HOLD;
          end else if (reinit_cnt == 32'(REINIT_CY - 1)) begin
            state <= fel_pkg::FEL_RUN;
          end
        end
      endcase
    end
  end
  wire running = (state == fel_pkg::FEL_RUN);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fire_enable      <= 1'b0;
      o_setpoint_enable  <= 1'b0;
      o_min_limit_enable <= 1'b0;
      o_led_red          <= 1'b1;
      o_comm_enable      <= 1'b0;
      o_bus_reset        <= 1'b1;
    end else begin
      o_fire_enable      <= running & ~hw_reset;
      o_setpoint_enable  <= running & ~lock_open;
      o_min_limit_enable <= running;
      o_led_red          <= ~running;
      o_comm_enable      <= running;
      o_bus_reset        <= hw_reset;
    end
  end

  // one-shot after reset and supply-return edge
  logic        was_running;
  logic [31:0] pulse_cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      was_running <= 1'b0;
      pulse_cnt   <= '0;
      supply_prev <= 1'b1;
    end else begin
      was_running <= running;
      supply_prev <= supply_ok;
      if (running && !was_running) begin
        pulse_cnt <= 32'(PULSE_CY);
      end else if (pulse_cnt != '0) begin
        pulse_cnt <= pulse_cnt - 32'h1;
      end
    end
  end

  // acknowledge must stay closed for two line periods
  logic [1:0] ack_lines;
  logic       ack_pulse;
  always_ff @(posedge i_clk) begin
    if (i_rst || !ack_closed) begin
      ack_lines <= '0;
      ack_pulse <= 1'b0;
    end else begin
      ack_pulse <= 1'b0;
      if (i_line_tick && ack_lines != 2'(`FEL_ACK_LINES)) begin
        ack_lines <= ack_lines + 2'h1;
        ack_pulse <= (ack_lines == 2'(`FEL_ACK_LINES - 1));
      end
    end
  end

  // event vector, bit n is event n; bit 0 unused
  logic [31:0] faults_latched;
  logic [31:0] ev_now;
  logic [31:0] ev_prev;
  logic [31:0] log_route;
  logic [31:0] relay_route [3];
  always_comb begin
    ev_now = i_events & ~`FEL_FAULT_MASK;
    ev_now = ev_now | faults_latched;
    ev_now[`FEL_EV_RESET]  = (pulse_cnt != '0);
    ev_now[`FEL_EV_LOCK]   = lock_open;
    ev_now[`FEL_EV_SUPPLY] = supply_ok & ~supply_prev;
    ev_now[`FEL_EV_COLL]   = |(faults_latched & `FEL_FAULT_MASK);
    ev_now[0] = 1'b0;
  end
  wire [31:0] ev_rise = ev_now & ~ev_prev;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      faults_latched <= '0;
      ev_prev        <= '0;
    end else begin
      ev_prev <= ev_now;
      // a fault arriving with the acknowledge is kept
      faults_latched <= (ack_pulse ? 32'h0 : faults_latched)
                        | (i_events & `FEL_FAULT_MASK);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_relay
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          o_relay[g] <= 1'b0;
        end else begin
          o_relay[g] <= |(ev_now & relay_route[g]);
        end
      end
    end
  endgenerate

  // logging queue: lowest pending event logged first
  logic [31:0] log_pend;
  logic [4:0]  pick;
  always_comb begin
    pick = '0;
    for (int n = 31; n > 0; n--) begin
      if (log_pend[n]) begin
        pick = 5'(n);
      end
    end
  end
  wire [31:0] pick_bit = 32'h1 << pick;

  // entry storage is never reset so it survives reset and outages
  logic [31:0]        mem_date  [DEPTH];
  logic [23:0]        mem_time  [DEPTH];
  logic [4:0]         mem_ev    [DEPTH];
  logic [LIMIT_W-1:0] mem_limit [DEPTH];
  logic [PW-1:0]      wptr;
  logic [PW:0]        count;
  always_ff @(posedge i_clk) begin
    if (pick != '0) begin
      mem_date[wptr]  <= i_date;
      mem_time[wptr]  <= i_time;
      mem_ev[wptr]    <= pick;
      mem_limit[wptr] <= i_limit;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      log_pend <= '0;
      wptr     <= '0;
      count    <= '0;
    end else begin
      log_pend <= (log_pend & ~pick_bit) | (ev_rise & log_route);
      if (pick != '0) begin
        wptr <= (wptr == PW'(DEPTH - 1)) ? '0 : wptr + PW'(1);
        if (count != (PW+1)'(DEPTH)) begin
          count <= count + (PW+1)'(1);
        end
      end
    end
  end

  // apb slave: one wait state, reads of mapped registers always allowed
  logic [PW-1:0] log_sel;
  logic          clr_pending;
  wire acc   = psel & penable & pready;
  wire do_wr = acc & pwrite & o_comm_enable;
  wire [PW-1:0] slot = wptr - PW'(count) + log_sel;
  logic [31:0] rd;
  logic        hit;
  always_comb begin
    hit = 1'b1;
    rd  = '0;
    unique case (paddr)
      `FEL_CTRL:      rd = '0;
      `FEL_STATUS:    rd = {26'h0, faults_latched != '0, lock_open, o_status_pending, 1'b0, state};
      `FEL_ACTIVE:    rd = ev_now;
      `FEL_LOG_ROUTE: rd = log_route;
      `FEL_RELAY0:    rd = relay_route[0];
      `FEL_RELAY1:    rd = relay_route[1];
      `FEL_RELAY2:    rd = relay_route[2];
      `FEL_LOG_INFO:  rd = {16'h0, 8'(wptr), 8'(count)};
      `FEL_LOG_SEL:   rd = 32'(log_sel);
      `FEL_LOG_DATE:  rd = mem_date[slot];
      `FEL_LOG_TIME:  rd = {8'h0, mem_time[slot]};
      `FEL_LOG_EVENT: rd = {11'h0, mem_ev[slot], 16'(mem_limit[slot])};
      default:        hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (~hit | (pwrite & ~o_comm_enable));
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      log_route      <= `FEL_LOG_ROUTE_RST;
      relay_route[0] <= `FEL_RELAY0_RST;
      relay_route[1] <= `FEL_RELAY1_RST;
      relay_route[2] <= `FEL_RELAY2_RST;
      log_sel        <= '0;
      soft_req       <= 1'b0;
      clr_pending    <= 1'b0;
    end else begin
      soft_req    <= do_wr && paddr == `FEL_CTRL && pwdata[`FEL_CTRL_SOFT];
      clr_pending <= do_wr && paddr == `FEL_CTRL && pwdata[`FEL_CTRL_ACK];
      if (do_wr) begin
        unique case (paddr)
          `FEL_LOG_ROUTE: log_route      <= pwdata;
          `FEL_RELAY0:    relay_route[0] <= pwdata;
          `FEL_RELAY1:    relay_route[1] <= pwdata;
          `FEL_RELAY2:    relay_route[2] <= pwdata;
          `FEL_LOG_SEL:   log_sel        <= pwdata[PW-1:0];
          default:        ;
        endcase
      end
    end
  end

  // panel indication and fieldbus message
  wire [31:0] fault_rise = ev_rise & `FEL_FAULT_MASK;
  logic [4:0] fpick;
  always_comb begin
    fpick = '0;
    for (int n = 31; n > 0; n--) begin
      if (fault_rise[n]) begin
        fpick = 5'(n);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_status_pending <= 1'b0;
      o_bus_msg        <= 1'b0;
      o_bus_msg_event  <= '0;
    end else begin
      // new event beats a same-cycle clear
      o_status_pending <= (o_status_pending & ~clr_pending) | (ev_rise != '0);
      o_bus_msg        <= (fpick != '0) & ~o_bus_reset;
      if (fpick != '0) begin
        o_bus_msg_event <= fpick;
      end
    end
  end
endmodule : fel_top

// ### design/fel_defines.svh
`ifndef FEL_DEFINES_SVH
`define FEL_DEFINES_SVH
// register byte offsets
`define FEL_CTRL        8'h00
`define FEL_STATUS      8'h04
`define FEL_ACTIVE      8'h08
`define FEL_LOG_ROUTE   8'h0C
`define FEL_RELAY0      8'h10
`define FEL_RELAY1      8'h14
`define FEL_RELAY2      8'h18
`define FEL_LOG_INFO    8'h1C
`define FEL_LOG_SEL     8'h20
`define FEL_LOG_DATE    8'h24
`define FEL_LOG_TIME    8'h28
`define FEL_LOG_EVENT   8'h2C
// control bits
`define FEL_CTRL_SOFT   0
`define FEL_CTRL_ACK    1
// event numbers
`define FEL_EV_RESET    7
`define FEL_EV_LOCK     8
`define FEL_EV_SUPPLY   19
`define FEL_EV_COLL     25
// reset values of routing
`define FEL_LOG_ROUTE_RST 32'h0008_0000
`define FEL_RELAY0_RST    32'h0100_0000
`define FEL_RELAY1_RST    32'h0000_0800
`define FEL_RELAY2_RST    32'h0000_0080
// events counted as faults for the collective fault
`define FEL_FAULT_MASK    32'hC13B_3A70
// timing
`define FEL_ACK_LINES     2
`define FEL_CLK_HZ        10000000
`define FEL_REINIT_US     100
`define FEL_PULSE_US      10
`endif

// ### design/fel_pkg.sv
package fel_pkg;
  typedef enum logic [1:0] {
    FEL_RUN,
    FEL_HOLD,
    FEL_REINIT
  } fel_state_e;
  typedef logic [31:0] fel_word_t;
endpackage : fel_pkg

// ### sim/fel_top_props.sv
`timescale 1ns/10ps
`include "fel_defines.svh"
module fel_top_chk (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_reset_closed,
  input wire logic        i_supply_ok,
  input wire logic        i_lock_closed,
  input wire logic [31:0] i_events,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        o_fire_enable,
  input wire logic        o_setpoint_enable,
  input wire logic        o_min_limit_enable,
  input wire logic        o_led_red,
  input wire logic        o_comm_enable,
  input wire logic        o_bus_reset,
  input wire logic        o_status_pending,
  input wire logic        o_bus_msg,
  input wire logic [4:0]  o_bus_msg_event
);
  localparam logic [31:0] FMASK = `FEL_FAULT_MASK;
  // internal event numbers are left out of the panel flag check
  localparam logic [31:0] EXT = 32'hFDF7_FE7E;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_fire; $fell(i_reset_closed) |-> ##[1:4] !o_fire_enable; endproperty
  a_fire: assert property (p_fire) else $error("firing kept after contact opened");
  property p_led; o_fire_enable |-> !o_led_red; endproperty
  a_led: assert property (p_led) else $error("red led while firing");
  property p_comm; o_led_red |-> !o_comm_enable && !o_fire_enable; endproperty
  a_comm: assert property (p_comm) else $error("comms open during reset");
  property p_busr; $fell(i_reset_closed) |-> ##[1:5] o_bus_reset; endproperty
  a_busr: assert property (p_busr) else $error("bus not reset by contact");
  property p_sup; $fell(i_supply_ok) |-> ##[1:5] o_led_red; endproperty
  a_sup: assert property (p_sup) else $error("low supply did not reset");
  property p_lock; !i_lock_closed [*4] |-> !o_setpoint_enable; endproperty
  a_lock: assert property (p_lock) else $error("setpoint live while locked");
  property p_min; o_min_limit_enable == o_comm_enable; endproperty
  a_min: assert property (p_min) else $error("limits and comms disagree");
  property p_pend; o_comm_enable && |(i_events & ~$past(i_events) & EXT) |-> ##[1:3] o_status_pending; endproperty
  a_pend: assert property (p_pend) else $error("no status flag for event");
  property p_msg; o_bus_msg |-> FMASK[o_bus_msg_event]; endproperty
  a_msg: assert property (p_msg) else $error("bus message for non-fault");
  property p_rdy; psel && penable && !pready |-> ##[1:2] pready; endproperty
  a_rdy: assert property (p_rdy) else $error("apb answer late");
endmodule : fel_top_chk
bind fel_top fel_top_chk i_chk (.i_clk, .i_rst, .i_reset_closed, .i_supply_ok, .i_lock_closed, .i_events,
  .psel, .penable, .pready, .pslverr, .o_fire_enable, .o_setpoint_enable, .o_min_limit_enable, .o_led_red,
  .o_comm_enable, .o_bus_reset, .o_status_pending, .o_bus_msg, .o_bus_msg_event);

// ### sim/fel_mains.sv
`timescale 1ns/10ps
module fel_mains #(
  parameter int LINE = 20
) (
  input  wire logic i_clk,
  input  wire logic i_ack_req,
  output logic      o_line_tick = 1'b0,
  output logic      o_ack_closed = 1'b0
);
  int cnt = 0;
  int held = 0;
  always_ff @(posedge i_clk) begin
    cnt <= (cnt == LINE - 1) ? 0 : cnt + 1;
    o_line_tick <= (cnt == LINE - 1);
    // one period of margin over the two required
    if (i_ack_req && held == 0) held <= 3 * LINE;
    else if (held > 0) held <= held - 1;
    o_ack_closed <= (held > 0);
  end
endmodule : fel_mains

// ### sim/test_fel_top.sv
`timescale 1ns/10ps
`include "fel_defines.svh"
module test_fel_top;
  localparam int LINE = 20;
  localparam logic [31:0] LOGEV = 32'h3CC4_440E;
  logic i_clk = 0, i_rst = 1, i_reset_closed = 1, i_supply_ok = 1, i_lock_closed = 1;
  logic psel = 0, penable = 0, pwrite = 0, ack_req = 0, k3q = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 0, i_events = 0, i_date = 0, prdata, rd, c;
  logic [23:0] i_time = 0;
  logic [15:0] i_limit = 0;
  logic pready, pslverr, o_fire_enable, o_setpoint_enable, o_min_limit_enable, o_led_red, o_comm_enable;
  logic o_bus_reset, o_status_pending, o_bus_msg, line_tick, ack_closed;
  logic [2:0] o_relay;
  logic [4:0] o_bus_msg_event, msg_ev, e_ev [16];
  logic [31:0] e_dt [16];
  logic [15:0] e_lim [16];
  int seed = 51126, n_fail = 0, cmp_count = 0, n_k3 = 0, e;
  fel_top #(.REINIT_CY(4), .PULSE_CY(3)) i_dut (.i_clk, .i_rst, .i_reset_closed, .i_supply_ok, .i_lock_closed,
    .i_ack_closed(ack_closed), .i_line_tick(line_tick), .i_events, .i_date, .i_time, .i_limit, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .o_fire_enable, .o_setpoint_enable, .o_min_limit_enable,
    .o_led_red, .o_comm_enable, .o_bus_reset, .o_relay, .o_status_pending, .o_bus_msg, .o_bus_msg_event);
  fel_mains #(.LINE(LINE)) i_mains (.i_clk, .i_ack_req(ack_req), .o_line_tick(line_tick), .o_ack_closed(ack_closed));
  initial forever #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_relay[2] === 1'b1 && k3q !== 1'b1) n_k3++;
    // the message is a one-cycle pulse, so keep its number for later checks
    if (o_bus_msg === 1'b1) msg_ev = o_bus_msg_event;
    k3q = o_relay[2];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge i_clk);
  endtask : apb
  task automatic wait_run();
    for (int i = 0; i < 60 && !(i > 0 && rd[1:0] === 2'd0); i++) apb(0, `FEL_STATUS, 0);
    repeat (2) @(posedge i_clk);
    chk(rd[1:0], 0);
    chk(o_led_red, 0);
  endtask : wait_run
  task automatic ack();
    ack_req <= 1;
    @(posedge i_clk);
    ack_req <= 0;
    repeat (4 * LINE) @(posedge i_clk);
    chk(o_relay[1:0], 0);
  endtask : ack
  task automatic summarize();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  function automatic logic [31:0] next_cnt(input logic [31:0] n);
    return (n >= 16) ? 32'd16 : n + 1;
  endfunction : next_cnt
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 0;
    wait_run();
    i_events <= 32'h0100_0800;
    repeat (3) @(posedge i_clk);
    chk(o_relay[1:0], 2'b11);
    i_events <= 0;
    ack();
    chk(msg_ev, 11);
    apb(1, `FEL_RELAY0, 32'h0200_0000);
    i_events <= 32'h0000_1000;
    repeat (3) @(posedge i_clk);
    i_events <= 0;
    repeat (3) @(posedge i_clk);
    chk(o_relay[0], 1);
    chk(o_status_pending, 1);
    chk(msg_ev, 12);
    ack();
    i_lock_closed <= 0;
    repeat (6) @(posedge i_clk);
    chk({o_setpoint_enable, o_min_limit_enable, o_comm_enable}, 3'b011);
    apb(0, `FEL_ACTIVE, 0);
    chk({rd[8], rd[0]}, 2'b10);
    i_lock_closed <= 1;
    apb(0, `FEL_LOG_INFO, 0);
    c = next_cnt(rd[7:0]);
    i_supply_ok <= 0;
    repeat (6) @(posedge i_clk);
    chk(o_led_red, 1);
    i_supply_ok <= 1;
    wait_run();
    apb(0, `FEL_LOG_INFO, 0);
    chk(rd[7:0], c);
    apb(1, `FEL_LOG_SEL, c - 1);
    apb(0, `FEL_LOG_EVENT, 0);
    chk(rd[20:16], `FEL_EV_SUPPLY);
    apb(1, `FEL_LOG_ROUTE, LOGEV);
    // twenty entries after the supply entry push out the five oldest
    for (int k = 0; k < 20; k++) begin
      do e = $random(seed) & 31; while (!LOGEV[e]);
      e_ev[k % 16] = e;
      e_dt[k % 16] = $random(seed);
      e_lim[k % 16] = $random(seed);
      i_events <= 32'h1 << e;
      i_date <= e_dt[k % 16];
      i_time <= k;
      i_limit <= e_lim[k % 16];
      repeat (3) @(posedge i_clk);
      i_events <= 0;
      repeat (3) @(posedge i_clk);
    end
    apb(0, `FEL_LOG_INFO, 0);
    chk(rd[7:0], 16);
    for (int s = 0; s < 16; s++) begin
      apb(1, `FEL_LOG_SEL, s);
      apb(0, `FEL_LOG_DATE, 0);
      chk(rd, e_dt[(s + 4) % 16]);
      apb(0, `FEL_LOG_TIME, 0);
      chk(rd, s + 4);
      apb(0, `FEL_LOG_EVENT, 0);
      chk(rd[20:0], {e_ev[(s + 4) % 16], e_lim[(s + 4) % 16]});
    end
    apb(1, `FEL_CTRL, 2);
    @(posedge i_clk);
    chk(o_status_pending, 0);
    i_events <= 32'h0000_0002;
    repeat (3) @(posedge i_clk);
    chk(o_status_pending, 1);
    i_events <= 0;
    chk(o_fire_enable, 1);
    i_reset_closed <= 0;
    repeat (6) @(posedge i_clk);
    chk({o_bus_reset, o_fire_enable}, 2'b10);
    apb(1, `FEL_CTRL, 0);
    chk(err, 1);
    i_reset_closed <= 1;
    wait_run();
    apb(1, `FEL_CTRL, 1);
    repeat (2) @(posedge i_clk);
    chk({o_bus_reset, o_led_red}, 2'b01);
    wait_run();
    apb(0, 8'h40, 0);
    chk(err, 1);
    repeat (20) @(posedge i_clk);
    chk(n_k3, 4);
    summarize();
  end
endmodule : test_fel_top
